// ### core/gpt_timer_ctl.sv
// Controller end: AXI4-Lite registers driving the timer link
`timescale 1ns/1ps
module gpt_timer_ctl
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link to the timer
  gpt_link_if.ctl LINK,
  // AXI4-Lite write address and data
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [AXI_AW-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [AXI_AW-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  // Sources from other modules and time base pin
  input wire logic [NSRC-1:0] SYNC_SOURCES,
  input wire logic EXT_CLK_PIN,
  // Interrupt
  output logic IRQ
);

  logic aw_hold_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic w_hold_q;
  logic [DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [EVT_N-1:0] int_status_q;
  logic [EVT_N-1:0] int_mask_q;
  logic [2:0] pin_q;
  logic pin_level_q;
  logic ext_tick_q;
  logic wr_go;
  logic rd_go;
  logic wr_dev;
  logic [EVT_N-1:0] evt;
  logic [EVT_N-1:0] w1c;

  // ****************************************
  // Write channel: address and data in either order
  // ****************************************
  assign AWREADY = !aw_hold_q && !bvalid_q;
  assign WREADY = !w_hold_q && !bvalid_q;
  assign wr_go = aw_hold_q && w_hold_q;
  assign wr_dev = wr_go && (aw_addr_q <= OFF_DEV_LAST);

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= AWADDR;
      end else if (wr_go) begin
        aw_hold_q <= 1'b0;
      end
      if (WVALID && WREADY) begin
        w_hold_q <= 1'b1;
        w_data_q <= WDATA;
        w_strb_q <= WSTRB;
      end else if (wr_go) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_dev || aw_addr_q == OFF_INT_STATUS ||
        aw_addr_q == OFF_INT_MASK) ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Read channel; yields to a write on the link
  // ****************************************
  assign ARREADY = !rvalid_q && !wr_go;
  assign rd_go = ARVALID && ARREADY;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      if (ARADDR <= OFF_DEV_LAST) begin
        rdata_q <= LINK.reg_rdata;
      end else if (ARADDR == OFF_INT_STATUS) begin
        rdata_q <= {{(DATA_W-EVT_N){1'b0}}, int_status_q};
      end else if (ARADDR == OFF_INT_MASK) begin
        rdata_q <= {{(DATA_W-EVT_N){1'b0}}, int_mask_q};
      end else begin
        rdata_q <= '0;
        rresp_q <= RESP_SLVERR;
      end
    end else if (RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // ****************************************
  // Link drive
  // ****************************************
  assign LINK.reg_wr = wr_dev;
  assign LINK.reg_idx = wr_go ? aw_addr_q[IDX_W+1:2] : ARADDR[IDX_W+1:2];
  assign LINK.reg_wdata = w_data_q;
  assign LINK.sync_sources = SYNC_SOURCES; // R9
  assign LINK.ext_tick = ext_tick_q; // R13

  // Pin time base: three stages, rising edge as one tick
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pin_q <= 3'h0;
      pin_level_q <= 1'b0;
      ext_tick_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[1:0], EXT_CLK_PIN};
      ext_tick_q <= 1'b0;
      if (pin_q[1] == pin_q[2] && pin_q[2] != pin_level_q) begin
        pin_level_q <= pin_q[2];
        ext_tick_q <= pin_q[2];
      end
    end
  end

  // ****************************************
  // Interrupt status, W1C, set wins
  // ****************************************
  assign evt = {LINK.sync_out, LINK.compare_event};
  assign w1c = (wr_go && aw_addr_q == OFF_INT_STATUS && w_strb_q[0]) ?
    w_data_q[EVT_N-1:0] : '0;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      int_status_q <= INT_RST;
      int_mask_q <= INT_RST;
    end else begin
      int_status_q <= (int_status_q & ~w1c) | evt;
      if (wr_go && aw_addr_q == OFF_INT_MASK && w_strb_q[0]) begin
        int_mask_q <= w_data_q[EVT_N-1:0];
      end
    end
  end

  // A set mask bit hides its event from the interrupt line
  assign IRQ = |(int_status_q & ~int_mask_q);
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

endmodule

// ### core/gpt_timer_dev.sv
// Timer end: dual 16-bit or cascaded 32-bit time base
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module gpt_timer_dev
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link to controller and other modules
  gpt_link_if.dev LINK,
  // Timer state
  output logic [HALF_W-1:0] TIMER_LOW,
  output logic [HALF_W-1:0] TIMER_HIGH,
  output logic TRIGGER_ARMED
);

  // ****************************************
  // Configuration
  // ****************************************
  logic on_q;
  logic capture_compare_select_q;
  logic [FUNC_W-1:0] function_select_field_q;
  logic wide_count_select_q;
  logic trigger_operation_enable_q;
  logic [SRC_W-1:0] sync_source_select_q;
  logic [CSEL_W-1:0] time_base_source_select_q;

  // ****************************************
  // Counters and status
  // ****************************************
  logic [HALF_W-1:0] low_count_reg_q;
  logic [HALF_W-1:0] high_count_reg_q;
  logic [HALF_W-1:0] low_period_reg_q;
  logic [HALF_W-1:0] high_period_reg_q;
  logic trigger_armed_status_q;
  logic sync_out_q;
  logic compare_event_q;

  // ****************************************
  // Decoded terms
  // ****************************************
  logic wr_ctrl;
  logic wr_stat;
  logic trigger_clear_request;
  logic timer_mode;
  logic tick;
  logic run;
  logic sync_hit;
  logic held;
  logic sync_clear;
  logic low_match;
  logic high_match;
  logic wide_match;
  logic low_wrap;
  logic step;
  logic [HALF_W-1:0] low_count_d;
  logic [HALF_W-1:0] high_count_d;
  logic primary_evt;
  logic compare_evt;

  assign wr_ctrl = LINK.reg_wr && (LINK.reg_idx == IDX_CTRL);
  assign wr_stat = LINK.reg_wr && (LINK.reg_idx == IDX_STAT);
  assign trigger_clear_request = wr_stat &&
    LINK.reg_wdata[STAT_TRIGGER_CLEAR_REQUEST_BIT];

  // Plain timer function only for this selection
  assign timer_mode = !capture_compare_select_q &&
    (function_select_field_q == FUNC_TIMER); // R1

  // Other time base sources arrive as one-cycle enables
  assign tick = (time_base_source_select_q == CLK_SYSTEM) ?
    1'b1 : LINK.ext_tick;
  assign run = on_q && timer_mode;

  // Selected input; code zero selects nothing
  assign sync_hit = (sync_source_select_q != SYNC_OFF) &&
    LINK.sync_sources[sync_source_select_q];

  // Trigger operation holds at zero while disarmed
  assign held = trigger_operation_enable_q &&
    !trigger_armed_status_q; // R10 R11
  assign sync_clear = !trigger_operation_enable_q && sync_hit; // R8

  assign low_match = low_count_reg_q == low_period_reg_q;
  assign high_match = high_count_reg_q == high_period_reg_q;
  assign wide_match = low_match && high_match;
  assign low_wrap = low_count_reg_q == HALF_MAX;
  assign step = run && tick && !held && !sync_clear;

  // ****************************************
  // Next count
  // ****************************************
  always_comb begin
    low_count_d = low_count_reg_q;
    high_count_d = high_count_reg_q;
    if (wide_count_select_q) begin
      if (wide_match) begin
        low_count_d = COUNT_RST; // R14
        high_count_d = COUNT_RST; // R14
      end else begin
        low_count_d = low_count_reg_q + 16'h0001;
        if (low_wrap) begin
          high_count_d = high_count_reg_q + 16'h0001; // R6
        end
      end
    end else begin
      low_count_d = low_match ? COUNT_RST :
        low_count_reg_q + 16'h0001; // R2 R3 R14
      high_count_d = high_match ? COUNT_RST :
        high_count_reg_q + 16'h0001; // R2 R4 R14
    end
  end

  // Primary match drives sync out; secondary never does
  assign primary_evt = step &&
    (wide_count_select_q ? wide_match : low_match); // R3 R4
  assign compare_evt = step &&
    (wide_count_select_q ? wide_match : high_match); // R5

  // ****************************************
  // Configuration register
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      on_q <= 1'b0;
      capture_compare_select_q <= 1'b0;
      function_select_field_q <= FUNC_TIMER;
      wide_count_select_q <= 1'b0;
      trigger_operation_enable_q <= 1'b0;
      sync_source_select_q <= SYNC_OFF;
      time_base_source_select_q <= CLK_SYSTEM;
    end else if (wr_ctrl) begin
      on_q <= LINK.reg_wdata[CTRL_ON_BIT];
      capture_compare_select_q <= LINK.reg_wdata[CTRL_CAPTURE_COMPARE_SELECT_BIT];
      function_select_field_q <=
        LINK.reg_wdata[CTRL_FUNC_LSB +: FUNC_W];
      wide_count_select_q <= LINK.reg_wdata[CTRL_WIDE_BIT]; // R2
      trigger_operation_enable_q <= LINK.reg_wdata[CTRL_TRIGGER_OPERATION_ENABLE_BIT];
      sync_source_select_q <= LINK.reg_wdata[CTRL_SYNC_LSB +: SRC_W];
      time_base_source_select_q <=
        LINK.reg_wdata[CTRL_CLK_LSB +: CSEL_W];
    end
  end

  // ****************************************
  // Period registers
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      low_period_reg_q <= PERIOD_RST;
      high_period_reg_q <= PERIOD_RST;
    end else if (LINK.reg_wr) begin
      if (LINK.reg_idx == IDX_LOW_PERIOD) begin
        low_period_reg_q <= LINK.reg_wdata[HALF_W-1:0];
      end
      if (LINK.reg_idx == IDX_HIGH_PERIOD) begin
        high_period_reg_q <= LINK.reg_wdata[HALF_W-1:0];
      end
    end
  end

  // ****************************************
  // Counters; software writes win over counting
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      low_count_reg_q <= COUNT_RST;
      high_count_reg_q <= COUNT_RST;
    end else begin
      if (trigger_clear_request ||
          (run && (held || sync_clear))) begin
        low_count_reg_q <= COUNT_RST; // R8 R10 R12
        high_count_reg_q <= COUNT_RST; // R8 R10 R12
      end else if (step) begin
        low_count_reg_q <= low_count_d;
        high_count_reg_q <= high_count_d;
      end
      if (LINK.reg_wr && (LINK.reg_idx == IDX_LOW_COUNT)) begin
        low_count_reg_q <= LINK.reg_wdata[HALF_W-1:0];
      end
      if (LINK.reg_wr && (LINK.reg_idx == IDX_HIGH_COUNT)) begin
        high_count_reg_q <= LINK.reg_wdata[HALF_W-1:0];
      end
    end
  end

  // ****************************************
  // Trigger armed status; a new trigger wins
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      trigger_armed_status_q <= 1'b0;
    end else if (run && held && sync_hit) begin
      trigger_armed_status_q <= 1'b1; // R15
    end else if (trigger_clear_request) begin
      trigger_armed_status_q <= 1'b0; // R12
    end
  end

  // ****************************************
  // Event pulses to other modules
  // ****************************************
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sync_out_q <= 1'b0;
      compare_event_q <= 1'b0;
    end else begin
      sync_out_q <= primary_evt; // R3
      compare_event_q <= compare_evt; // R5
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  always_comb begin
    LINK.reg_rdata = '0;
    case (LINK.reg_idx)
      IDX_CTRL: begin
        LINK.reg_rdata[CTRL_FUNC_LSB +: FUNC_W] = function_select_field_q;
        LINK.reg_rdata[CTRL_CAPTURE_COMPARE_SELECT_BIT] = capture_compare_select_q;
        LINK.reg_rdata[CTRL_WIDE_BIT] = wide_count_select_q;
        LINK.reg_rdata[CTRL_TRIGGER_OPERATION_ENABLE_BIT] = trigger_operation_enable_q;
        LINK.reg_rdata[CTRL_SYNC_LSB +: SRC_W] = sync_source_select_q;
        LINK.reg_rdata[CTRL_CLK_LSB +: CSEL_W] =
          time_base_source_select_q;
        LINK.reg_rdata[CTRL_ON_BIT] = on_q;
      end
      IDX_STAT: begin
        LINK.reg_rdata[STAT_ARMED_BIT] = trigger_armed_status_q;
      end
      IDX_LOW_COUNT: begin
        LINK.reg_rdata[HALF_W-1:0] = low_count_reg_q;
      end
      IDX_HIGH_COUNT: begin
        LINK.reg_rdata[HALF_W-1:0] = high_count_reg_q;
      end
      IDX_LOW_PERIOD: begin
        LINK.reg_rdata[HALF_W-1:0] = low_period_reg_q;
      end
      IDX_HIGH_PERIOD: begin
        LINK.reg_rdata[HALF_W-1:0] = high_period_reg_q;
      end
      default: begin
        LINK.reg_rdata = '0;
      end
    endcase
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign LINK.sync_out = sync_out_q;
  assign LINK.compare_event = compare_event_q;
  assign TIMER_LOW = low_count_reg_q;
  assign TIMER_HIGH = high_count_reg_q;
  assign TRIGGER_ARMED = trigger_armed_status_q;

endmodule

// ### pkg/gpt_link_if.sv
// Interface joining the timer and its controller
`timescale 1ns/1ps
interface gpt_link_if;
  import gpt_pkg::*;

  logic reg_wr;
  logic [IDX_W-1:0] reg_idx;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] reg_rdata;
  logic [NSRC-1:0] sync_sources;
  logic ext_tick;
  logic sync_out;
  logic compare_event;

  modport dev (
    input reg_wr,
    input reg_idx,
    input reg_wdata,
    output reg_rdata,
    input sync_sources,
    input ext_tick,
    output sync_out,
    output compare_event
  );

  modport ctl (
    output reg_wr,
    output reg_idx,
    output reg_wdata,
    input reg_rdata,
    output sync_sources,
    output ext_tick,
    input sync_out,
    input compare_event
  );
endinterface

// ### pkg/gpt_pkg.sv
// Package of constants for the general purpose timer
// ****************************************
// Function
// R1 - Timer only with select zero, function 0000
// R2 - Wide select: two 16-bit or one 32-bit
// R3 - Primary uses low regs, drives sync out
// R4 - Secondary uses high regs, no sync output
// R5 - Dual mode compare event from high period
// R6 - 32-bit: high increments on low overflow
// R7 - Software sets wide select before count init
// R8 - Sync operation clears timer on selected input
// R9 - Software never selects sync source 11111
// R10 - Trigger operation holds zero until input
// R11 - Keeps running while trigger armed set
// R12 - Trigger clear disarms, resets, holds timer
// R13 - Trigger operation only with system clock; code allows it on any time base source
// R14 - Count returns to zero after period match
// R15 - Input while held sets trigger armed
// ****************************************
package gpt_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int HALF_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 3;
  localparam int SRC_W = 5;
  localparam int NSRC = 32;
  localparam int CSEL_W = 3;
  localparam int FUNC_W = 4;
  localparam int AXI_AW = 8;
  localparam int EVT_N = 2;

  // ****************************************
  // Device register indices on the link
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_CTRL = 3'h0;
  localparam logic [IDX_W-1:0] IDX_STAT = 3'h1;
  localparam logic [IDX_W-1:0] IDX_LOW_COUNT = 3'h2;
  localparam logic [IDX_W-1:0] IDX_HIGH_COUNT = 3'h3;
  localparam logic [IDX_W-1:0] IDX_LOW_PERIOD = 3'h4;
  localparam logic [IDX_W-1:0] IDX_HIGH_PERIOD = 3'h5;

  // ****************************************
  // Control register field positions
  // ****************************************
  localparam int CTRL_FUNC_LSB = 0;
  localparam int CTRL_CAPTURE_COMPARE_SELECT_BIT = 4;
  localparam int CTRL_WIDE_BIT = 5;
  localparam int CTRL_TRIGGER_OPERATION_ENABLE_BIT = 7;
  localparam int CTRL_SYNC_LSB = 8;
  localparam int CTRL_CLK_LSB = 13;
  localparam int CTRL_ON_BIT = 16;

  // ****************************************
  // Status register field positions
  // ****************************************
  localparam int STAT_TRIGGER_CLEAR_REQUEST_BIT = 5;
  localparam int STAT_ARMED_BIT = 7;

  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [FUNC_W-1:0] FUNC_TIMER = 4'h0;
  localparam logic [SRC_W-1:0] SYNC_OFF = 5'h00;
  localparam logic [CSEL_W-1:0] CLK_SYSTEM = 3'h0;
  localparam logic [HALF_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [HALF_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [HALF_W-1:0] HALF_MAX = 16'hFFFF;

  // ****************************************
  // Controller register byte offsets
  // ****************************************
  localparam logic [AXI_AW-1:0] OFF_DEV_LAST = 8'h14;
  localparam logic [AXI_AW-1:0] OFF_INT_STATUS = 8'h20;
  localparam logic [AXI_AW-1:0] OFF_INT_MASK = 8'h24;
  localparam logic [EVT_N-1:0] INT_RST = 2'h0;
  localparam int EVT_COMPARE = 0;
  localparam int EVT_SYNC = 1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### testbench/gpt_timer_props.sv
// Checker of the timer link and count behaviour
`timescale 1ns/1ps
module gpt_timer_props
  import gpt_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // Link signals
  input wire logic reg_wr,
  input wire logic [IDX_W-1:0] reg_idx,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NSRC-1:0] sync_sources,
  input wire logic ext_tick,
  input wire logic sync_out,
  input wire logic compare_event,
  // Timer state
  input wire logic [HALF_W-1:0] TIMER_LOW,
  input wire logic [HALF_W-1:0] TIMER_HIGH,
  input wire logic TRIGGER_ARMED
);
  // ********************
  // Shadow of the setup
  // ********************
  logic [DATA_W-1:0] ctrl_q;
  logic [HALF_W-1:0] lper_q;
  logic [HALF_W-1:0] hper_q;
  logic [SRC_W-1:0] src;
  logic run, tick, trg, sel, step, hold, clr, zero, lhit, hhit, wide;
  logic [HALF_W-1:0] lnxt;
  logic [HALF_W-1:0] hnxt;
  logic [DATA_W-1:0] wnxt;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl_q <= 32'h00000000;
      lper_q <= PERIOD_RST;
      hper_q <= PERIOD_RST;
    end else if (reg_wr) begin
      case (reg_idx)
        IDX_CTRL: ctrl_q <= reg_wdata;
        IDX_LOW_PERIOD: lper_q <= reg_wdata[HALF_W-1:0];
        IDX_HIGH_PERIOD: hper_q <= reg_wdata[HALF_W-1:0];
        default: ;
      endcase
    end
  end

  assign src = ctrl_q[CTRL_SYNC_LSB +: SRC_W];
  assign run = ctrl_q[CTRL_ON_BIT] && !ctrl_q[CTRL_CAPTURE_COMPARE_SELECT_BIT]
    && ctrl_q[CTRL_FUNC_LSB +: FUNC_W] == FUNC_TIMER;
  assign tick = ctrl_q[CTRL_CLK_LSB +: CSEL_W] == CLK_SYSTEM || ext_tick;
  assign trg = ctrl_q[CTRL_TRIGGER_OPERATION_ENABLE_BIT];
  assign wide = ctrl_q[CTRL_WIDE_BIT];
  assign sel = src != SYNC_OFF && sync_sources[src];
  assign step = run && tick && !reg_wr && (trg ? TRIGGER_ARMED : !sel);
  assign hold = run && tick && trg && !TRIGGER_ARMED;
  assign clr = reg_wr && reg_idx == IDX_STAT && reg_wdata[STAT_TRIGGER_CLEAR_REQUEST_BIT];
  assign zero = TIMER_LOW == COUNT_RST && TIMER_HIGH == COUNT_RST;
  assign lhit = TIMER_LOW == lper_q;
  assign hhit = TIMER_HIGH == hper_q;
  assign lnxt = lhit ? COUNT_RST : TIMER_LOW + 16'h0001;
  assign hnxt = hhit ? COUNT_RST : TIMER_HIGH + 16'h0001;
  assign wnxt = lhit && hhit ? 32'h00000000
    : {TIMER_HIGH, TIMER_LOW} + 32'h00000001;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  AST_STOP_FREEZE: assert property (
    !(run && (tick || trg || sel)) && !reg_wr
    |=> $stable(TIMER_LOW) && $stable(TIMER_HIGH))
    else $error("Counts moved while stopped");
  AST_LOW_STEP: assert property (
    step && !wide |=> TIMER_LOW == $past(lnxt))
    else $error("Low count stepped wrongly");
  AST_HIGH_STEP: assert property (
    step && !wide |=> TIMER_HIGH == $past(hnxt))
    else $error("High count stepped wrongly");
  AST_SYNC_PULSE: assert property (
    step |=> sync_out == $past(lhit && (hhit || !wide)))
    else $error("Sync output wrong");
  AST_CMP_PULSE: assert property (
    step |=> compare_event == $past(hhit && (lhit || !wide)))
    else $error("Compare event wrong");
  AST_WIDE_STEP: assert property (
    step && wide |=> {TIMER_HIGH, TIMER_LOW} == $past(wnxt))
    else $error("Wide count stepped wrongly");
  AST_SYNC_CLEAR: assert property (
    run && tick && !trg && sel && !reg_wr |=> zero)
    else $error("Sync input did not clear counts");
  AST_TRIG_HOLD: assert property (
    hold && !reg_wr |=> zero)
    else $error("Counts not held before trigger");
  AST_ARM_SET: assert property (
    hold && sel && !reg_wr |=> TRIGGER_ARMED)
    else $error("Trigger did not arm");
  AST_ARM_KEEP: assert property (
    run && trg && TRIGGER_ARMED && !reg_wr |=> TRIGGER_ARMED)
    else $error("Armed state dropped");
  AST_TRIG_CLEAR: assert property (
    clr && !(hold && sel) |=> !TRIGGER_ARMED && zero)
    else $error("Trigger clear failed");

  cover property (step && wide && lhit);
  cover property (run && tick && !trg && sel);
  cover property (hold && sel);
  cover property (clr && TRIGGER_ARMED);
endmodule

// ### testbench/test_gpt_timer.sv
// Self-checking bench for the timer and its AXI4-Lite controller
`timescale 1ns/1ps
module test_gpt_timer
  import gpt_pkg::*;
  ;
  logic CORE_CLK, SRST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY, EXT_CLK_PIN, IRQ, TRIGGER_ARMED;
  logic [AXI_AW-1:0] AWADDR, ARADDR;
  logic [DATA_W-1:0] WDATA, RDATA, d;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  logic [NSRC-1:0] SYNC_SOURCES;
  logic [HALF_W-1:0] TIMER_LOW, TIMER_HIGH;
  logic [33:0] rd_q[$];
  logic [1:0] b_q[$];
  logic [DATA_W-1:0] offc[3] = '{32'h00010010, 32'h00010001, 32'h0001000F};
  int fail_count, checks, seed;

  gpt_link_if link ();
  gpt_timer_dev gpt_timer_dev_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .LINK(link.dev), .TIMER_LOW(TIMER_LOW), .TIMER_HIGH(TIMER_HIGH),
    .TRIGGER_ARMED(TRIGGER_ARMED));
  gpt_timer_ctl gpt_timer_ctl_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .LINK(link.ctl), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP), .SYNC_SOURCES(SYNC_SOURCES),
    .EXT_CLK_PIN(EXT_CLK_PIN), .IRQ(IRQ));
  gpt_timer_props gpt_timer_props_inst (.CORE_CLK(CORE_CLK), .SRST(SRST),
    .reg_wr(link.reg_wr), .reg_idx(link.reg_idx), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .sync_sources(link.sync_sources),
    .ext_tick(link.ext_tick), .sync_out(link.sync_out),
    .compare_event(link.compare_event), .TIMER_LOW(TIMER_LOW),
    .TIMER_HIGH(TIMER_HIGH), .TRIGGER_ARMED(TRIGGER_ARMED));

  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  // ********************
  // Compare and bus tasks
  // ********************
  task automatic chk_read(input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error read expected %h seen %h", e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic [1:0] e,
                          input logic [1:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Readies and valids are looked at mid-cycle, acted on at the next edge
  task automatic wait_hi(ref logic s);
    logic t;
    do begin
      @(negedge CORE_CLK);
      t = s;
      @(posedge CORE_CLK);
    end while (!t);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] r);
    logic ta, tw;
    @(posedge CORE_CLK);
    b_q.push_back(r);
    AWADDR <= a;
    WDATA <= v;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(negedge CORE_CLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      @(posedge CORE_CLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end while ((AWVALID && !ta) || (WVALID && !tw));
    wait_hi(BVALID);
    BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge CORE_CLK);
    rd_q.push_back(e);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    wait_hi(ARREADY);
    ARVALID <= 1'b0;
    wait_hi(RVALID);
    RREADY <= 1'b0;
  endtask

  task automatic irq_is(input logic e);
    @(negedge CORE_CLK);
    chk_flag("irq", {1'b0, e}, {1'b0, IRQ});
  endtask

  task automatic end_of_test();
    $display("Checks %0d errors %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Results are matched against the oldest note in each queue
  always @(negedge CORE_CLK) begin
    if (RVALID && RREADY) chk_read(rd_q.pop_front(), {RRESP, RDATA});
    if (BVALID && BREADY) chk_flag("bresp", b_q.pop_front(), BRESP);
  end

  initial begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial begin
    seed = 26;
    fail_count = 0;
    checks = 0;
    SRST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, EXT_CLK_PIN} = 6'h00;
    {AWADDR, ARADDR, WDATA, SYNC_SOURCES} = 80'h0;
    WSTRB = 4'hF;
    repeat (5) @(posedge CORE_CLK);
    SRST <= 1'b0;
    rd(8'h00, {RESP_OKAY, 32'h00000000});
    rd(8'h14, {RESP_OKAY, 32'h0000FFFF});
    rd(8'h40, {RESP_SLVERR, 32'h00000000});
    wr(8'h40, 32'h00000001, RESP_SLVERR);
    foreach (offc[i]) begin
      d = $random(seed);
      wr(8'h00, offc[i], RESP_OKAY);
      wr(8'h08, {16'h0000, d[15:0]}, RESP_OKAY);
      repeat (8) @(posedge CORE_CLK);
      rd(8'h08, {RESP_OKAY, 16'h0000, d[15:0]});
    end
    wr(8'h00, 32'h00002020, RESP_OKAY);
    wr(8'h08, 32'h0000FFFE, RESP_OKAY);
    wr(8'h0C, 32'h00000007, RESP_OKAY);
    wr(8'h00, 32'h00012020, RESP_OKAY);
    repeat (3) begin
      @(posedge CORE_CLK);
      EXT_CLK_PIN <= 1'b1;
      repeat (5) @(posedge CORE_CLK);
      EXT_CLK_PIN <= 1'b0;
      repeat (5) @(posedge CORE_CLK);
    end
    rd(8'h08, {RESP_OKAY, 32'h00000001});
    rd(8'h0C, {RESP_OKAY, 32'h00000008});
    wr(8'h00, 32'h00000000, RESP_OKAY);
    wr(8'h08, 32'h00000000, RESP_OKAY);
    wr(8'h0C, 32'h00000000, RESP_OKAY);
    wr(8'h10, 32'h00000003, RESP_OKAY);
    wr(8'h14, 32'h00000005, RESP_OKAY);
    wr(8'h00, 32'h00010000, RESP_OKAY);
    repeat (30) @(posedge CORE_CLK);
    wr(8'h00, 32'h00000000, RESP_OKAY);
    rd(8'h20, {RESP_OKAY, 32'h00000003});
    irq_is(1'b1);
    wr(8'h24, 32'h00000003, RESP_OKAY);
    irq_is(1'b0);
    wr(8'h24, 32'h00000000, RESP_OKAY);
    wr(8'h20, 32'h00000003, RESP_OKAY);
    rd(8'h20, {RESP_OKAY, 32'h00000000});
    irq_is(1'b0);
    wr(8'h00, 32'h00010300, RESP_OKAY);
    repeat (20) begin
      @(posedge CORE_CLK);
      SYNC_SOURCES <= $random(seed) | 32'h00000008;
    end
    rd(8'h08, {RESP_OKAY, 32'h00000000});
    rd(8'h0C, {RESP_OKAY, 32'h00000000});
    SYNC_SOURCES <= 32'h00000000;
    wr(8'h00, 32'h00010280, RESP_OKAY);
    rd(8'h04, {RESP_OKAY, 32'h00000000});
    rd(8'h08, {RESP_OKAY, 32'h00000000});
    SYNC_SOURCES <= 32'h00000004;
    @(posedge CORE_CLK);
    SYNC_SOURCES <= 32'h00000000;
    repeat (6) @(posedge CORE_CLK);
    rd(8'h04, {RESP_OKAY, 32'h00000080});
    wr(8'h04, 32'h00000020, RESP_OKAY);
    rd(8'h04, {RESP_OKAY, 32'h00000000});
    rd(8'h08, {RESP_OKAY, 32'h00000000});
    end_of_test();
  end
endmodule
